/* File: src/tfa_core.sv */
/*
 * post-qualification logic of a capacitive touch controller: buzzer
 * feedback, mutually exclusive button arbiter, touch timeout timers and
 * startup self-test with failure signalling on the event interrupt.
 * assumes: qualification engine, self-test comparators, event buffer
 * and configuration store all run on clk; the i2c engine reads
 * slave_ack_ok; the pad ring resolves buzz_pin_out / buzz_pin_oe_n.
 */
// How it works
// RULE1: new touch starts buzzer square wave
// RULE2: buzzer uses input eleven, excluded from sensing
// RULE3: buzz ends at duration or last release
// RULE4: tone selectable from 1 kHz to 4 kHz
// RULE5: buzzer pin push-pull or open-drain
// RULE6: mutex reports one input until released
// RULE7: other inputs qualified but withheld from host
// RULE8: simultaneous touches report largest delta
// RULE9: after release, report other active input
// RULE10: otherwise report highest index still active
// RULE11: mutex timeout runs on reported input only
// RULE12: self-test enabled inputs before scanning
// RULE13: failed inputs disabled, scanning on the rest
// RULE14: errors toggle interrupt 2 Hz for 2 s
// RULE15: programmer loads profile over config port
// RULE16: interrupt output is push-pull
// RULE17: acknowledge address only while interrupt low
// RULE18: slider inputs exempt from mutual exclusion
// RULE19: idle buzzer rests low, no extension
`timescale 1ns/1ps
`default_nettype none
`include "tfa_defs.svh"

module tfa_core import tfa_pkg::*; #(
	parameter int N_SENSE = `TFA_SENSE_COUNT,
	parameter int MS_CYCLES = `TFA_MS_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire tfa_cfg_t cfg,
	input wire logic [11:0] qual_active,
	input wire tfa_delta_t touch_delta,
	input wire logic test_done,
	input wire logic [11:0] test_fault,
	input wire logic pkt_pending,
	output logic [11:0] scan_enable,
	output logic scan_start,
	output logic test_req,
	output tfa_evt_t host_evt,
	output logic [11:0] timeout_release,
	output logic event_irq_out,
	output logic slave_ack_ok,
	output logic buzz_pin_out,
	output logic buzz_pin_oe_n
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (N_SENSE != `TFA_SENSE_COUNT || MS_CYCLES < 2 || MS_CYCLES > 65535) begin : g_bad_param
		$error("tfa_core: unsupported N_SENSE or MS_CYCLES");
	end

	// ------------------------------------------------------------
	// millisecond timebase
	// ------------------------------------------------------------
	logic [15:0] ms_cnt; // cycles into the current ms
	logic ms_tick; // one-cycle enable every ms
	logic [15:0] next_ms_cnt;
	logic next_ms_tick;

	always_comb begin
		next_ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
		next_ms_cnt = next_ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt <= 16'h0000;
			ms_tick <= 1'b0;
		end else begin
			ms_cnt <= next_ms_cnt;
			ms_tick <= next_ms_tick;
		end
	end

	// ------------------------------------------------------------
	// startup self-test and interrupt pin
	// ------------------------------------------------------------
	tfa_state_t state;
	tfa_state_t next_state;
	logic [11:0] fail; // inputs that failed the self-test
	logic [11:0] next_fail;
	logic [11:0] st_ms; // ms into the current toggle
	logic [11:0] next_st_ms;
	logic [3:0] toggles; // toggles done so far
	logic [3:0] next_toggles;
	logic [11:0] next_scan_enable;
	logic next_test_req;
	logic next_irq;
	logic next_ack;

	// next values of the startup sequence
	always_comb begin
		next_state = state;
		next_fail = fail;
		next_st_ms = st_ms;
		next_toggles = toggles;
		next_test_req = 1'b0;
		next_irq = event_irq_out;
		unique case (state)
			TFA_WAIT: begin
				next_test_req = cfg.selftest_en; // RULE12
				next_state = cfg.selftest_en ? TFA_TEST : TFA_RUN;
			end
			TFA_TEST: begin
				next_test_req = ~test_done;
				if (test_done) begin
					next_fail = test_fault & cfg.sense_en; // RULE13
					next_st_ms = 12'h000;
					next_toggles = 4'h1;
					// first toggle at once: the pin drops from its idle high
					next_irq = (|(test_fault & cfg.sense_en)) ? 1'b0 : 1'b1; // RULE14
					next_state = (|(test_fault & cfg.sense_en)) ? TFA_SIGNAL : TFA_RUN;
				end
			end
			TFA_SIGNAL: begin
				if (ms_tick) begin
					next_st_ms = st_ms + 12'h001;
					if (st_ms == 12'(`TFA_ERR_TOGGLE_MS - 1)) begin
						next_st_ms = 12'h000;
						if (toggles == 4'(`TFA_ERR_TOGGLES)) begin
							next_state = TFA_RUN; // RULE14
						end else begin
							next_irq = ~event_irq_out; // RULE14
							next_toggles = toggles + 4'h1;
						end
					end
				end
			end
			TFA_RUN: begin
				// low means a packet waits; always driven both ways
				next_irq = ~pkt_pending; // RULE16
			end
		endcase
		// entering run: the pin follows the event buffer from the first cycle
		if (next_state == TFA_RUN && state != TFA_RUN) begin
			next_irq = ~pkt_pending;
		end
		next_ack = (next_state == TFA_RUN) & ~next_irq; // RULE17
		next_scan_enable = 12'h000;
		if (next_state == TFA_RUN) begin
			next_scan_enable = cfg.sense_en & ~next_fail; // RULE13
			if (cfg.buzz_en) begin
				next_scan_enable[`TFA_BUZZ_PIN] = 1'b0; // RULE2
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= TFA_WAIT;
			fail <= 12'h000;
			st_ms <= 12'h000;
			toggles <= 4'h0;
			test_req <= 1'b0;
			event_irq_out <= `TFA_IRQ_RESET;
			slave_ack_ok <= 1'b0;
			scan_enable <= 12'h000;
			scan_start <= 1'b0;
		end else begin
			state <= next_state;
			fail <= next_fail;
			st_ms <= next_st_ms;
			toggles <= next_toggles;
			test_req <= next_test_req;
			event_irq_out <= next_irq;
			slave_ack_ok <= next_ack;
			scan_enable <= next_scan_enable;
			scan_start <= (next_state == TFA_RUN); // RULE13
		end
	end

	// ------------------------------------------------------------
	// buzzer on/off
	// ------------------------------------------------------------
	logic [11:0] live; // qualified active on a scanned input
	logic [11:0] prev_live;
	logic buzz_on;
	logic next_buzz_on;
	logic [15:0] buzz_ms_cnt;
	logic [15:0] next_buzz_ms_cnt;
	logic wave; // tone from the generator

	assign live = qual_active & scan_enable;

	// a fresh touch while sounding is ignored, so the buzz never stretches
	always_comb begin
		next_buzz_on = buzz_on;
		next_buzz_ms_cnt = buzz_ms_cnt;
		if (!buzz_on) begin
			next_buzz_ms_cnt = 16'h0000;
			next_buzz_on = cfg.buzz_en & (|(live & ~prev_live)); // RULE1
		end else if (!cfg.buzz_en || !(|live)) begin
			next_buzz_on = 1'b0; // RULE3
		end else if (ms_tick) begin
			next_buzz_ms_cnt = buzz_ms_cnt + 16'h0001;
			if (buzz_ms_cnt + 16'h0001 >= cfg.buzz_ms) begin
				next_buzz_on = 1'b0; // RULE3
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_live <= 12'h000;
			buzz_on <= 1'b0;
			buzz_ms_cnt <= 16'h0000;
		end else begin
			prev_live <= live;
			buzz_on <= next_buzz_on; // RULE19
			buzz_ms_cnt <= next_buzz_ms_cnt;
		end
	end

	tfa_tone u_tone (
		.clk(clk),
		.rstn(rstn),
		.run(buzz_on),
		.khz(cfg.buzz_khz),
		.wave(wave)
	);

	// ------------------------------------------------------------
	// buzzer pin drive
	// ------------------------------------------------------------
	logic next_pin_out;
	logic next_pin_oe_n;

	always_comb begin
		next_pin_out = 1'b0;
		next_pin_oe_n = 1'b1; // pin left to the sensing front end
		if (cfg.buzz_en) begin
			if (cfg.buzz_od) begin
				// open-drain: pull low, let go for the high half
				next_pin_oe_n = buzz_on & wave; // RULE5
			end else begin
				next_pin_oe_n = 1'b0; // RULE2
				next_pin_out = buzz_on & wave; // RULE19
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			buzz_pin_out <= 1'b0;
			buzz_pin_oe_n <= 1'b1;
		end else begin
			buzz_pin_out <= next_pin_out;
			buzz_pin_oe_n <= next_pin_oe_n;
		end
	end

	// ------------------------------------------------------------
	// host event arbiter
	// ------------------------------------------------------------
	logic [11:0] vis; // button inputs the host may hear of
	logic [11:0] shadow; // what the host believes is active
	logic [11:0] next_shadow;
	tfa_evt_t next_evt;

	function automatic logic [3:0] lowest(input logic [11:0] m);
		lowest = 4'h0;
		for (int i = 11; i >= 0; i--) begin
			if (m[i]) lowest = 4'(i);
		end
	endfunction

	function automatic logic [3:0] highest(input logic [11:0] m);
		highest = 4'h0;
		for (int i = 0; i < 12; i++) begin
			if (m[i]) highest = 4'(i);
		end
	endfunction

	// ties in delta go to the lower input number
	function automatic logic [3:0] largest(input logic [11:0] m, input tfa_delta_t d);
		logic [15:0] best;
		best = 16'h0000;
		largest = lowest(m);
		for (int i = 0; i < 12; i++) begin
			if (m[i] && d[i] > best) begin
				best = d[i];
				largest = 4'(i);
			end
		end
	endfunction

	assign vis = live & ~cfg.slider_mask; // RULE18

	// one event per cycle at most; the event buffer takes every pulse
	always_comb begin
		next_shadow = shadow;
		next_evt = '0;
		if (cfg.mutex_en) begin
			if (|(shadow & ~vis)) begin
				next_evt.valid = 1'b1; // RULE9
				next_evt.is_release = 1'b1;
				next_evt.index = lowest(shadow & ~vis);
				next_shadow = shadow & vis;
			end else if (shadow == 12'h000 && |vis) begin
				next_evt.valid = 1'b1; // RULE6
				if (|(vis & ~prev_live)) begin
					next_evt.index = largest(vis & ~prev_live, touch_delta); // RULE8
				end else begin
					next_evt.index = highest(vis); // RULE10
				end
				next_shadow[next_evt.index] = 1'b1;
			end
			// any other change stays internal until the reported one goes
		end else if (|(shadow ^ vis)) begin
			next_evt.valid = 1'b1;
			next_evt.index = lowest(shadow ^ vis);
			next_evt.is_release = shadow[next_evt.index];
			next_shadow[next_evt.index] = vis[next_evt.index];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shadow <= 12'h000;
			host_evt <= '0;
		end else begin
			shadow <= next_shadow; // RULE7
			host_evt <= next_evt;
		end
	end

	// ------------------------------------------------------------
	// touch timeout, one timer per input
	// ------------------------------------------------------------
	for (genvar g = 0; g < 12; g++) begin : g_tmo
		logic [15:0] tmo; // ms this touch has lasted
		logic [15:0] next_tmo;
		logic fired; // already forced; wait for the drop
		logic next_fired;
		logic run;
		logic next_rel;

		// under mutex only the reported touch (or a slider input) ages
		assign run = cfg.timeout_en & live[g] & (~cfg.mutex_en | shadow[g] | cfg.slider_mask[g]); // RULE11

		always_comb begin
			next_tmo = tmo;
			next_fired = fired;
			next_rel = 1'b0;
			if (!run) begin
				next_tmo = 16'h0000;
				next_fired = 1'b0;
			end else if (ms_tick && !fired) begin
				next_tmo = tmo + 16'h0001;
				if (tmo + 16'h0001 >= cfg.timeout_ms) begin
					next_rel = 1'b1;
					next_fired = 1'b1;
				end
			end
		end

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				tmo <= 16'h0000;
				fired <= 1'b0;
				timeout_release[g] <= 1'b0;
			end else begin
				tmo <= next_tmo;
				fired <= next_fired;
				timeout_release[g] <= next_rel;
			end
		end
	end

endmodule
`default_nettype wire

/* File: src/tfa_defs.svh */
/*
 * timing counts, pin positions and reset values for the touch feedback,
 * arbiter and self-test block.
 * assumes: included by bare name from files that need the figures.
 */
`ifndef TFA_DEFS_SVH
`define TFA_DEFS_SVH

// ------------------------------------------------------------
// clock and millisecond timebase
// ------------------------------------------------------------
`define TFA_CLK_HZ 40000000
`define TFA_CLK_NS 25
`define TFA_MS_NS 1000000
`define TFA_MS_CYC (`TFA_MS_NS / `TFA_CLK_NS)

// ------------------------------------------------------------
// self-test failure signalling
// ------------------------------------------------------------
`define TFA_ERR_BLINK_HZ 2
`define TFA_ERR_TOGGLE_MS (1000 / (2 * `TFA_ERR_BLINK_HZ))
`define TFA_ERR_SIGNAL_MS 2000
`define TFA_ERR_TOGGLES (`TFA_ERR_SIGNAL_MS / `TFA_ERR_TOGGLE_MS)

// ------------------------------------------------------------
// buzzer tone: code k selects (k+1) kHz, 1 kHz to 4 kHz
// ------------------------------------------------------------
`define TFA_BUZZ_MIN_KHZ 1
`define TFA_BUZZ_HALF(k) (`TFA_CLK_HZ / (2 * 1000 * ((k) + `TFA_BUZZ_MIN_KHZ)))
`define TFA_BUZZ_PIN 11

// ------------------------------------------------------------
// reset values and sensing input count
// ------------------------------------------------------------
`define TFA_IRQ_RESET 1'b1
`define TFA_SENSE_COUNT 12

`endif

/* File: src/tfa_pkg.sv */
/*
 * types shared by the touch feedback, arbiter and self-test block.
 * assumes: compiled before every module that imports it.
 */
package tfa_pkg;

	// configuration profile as loaded over the configuration port
	typedef struct packed {
		logic buzz_en; // buzzer replaces sensing on input eleven
		logic buzz_od; // 1: open-drain, 0: push-pull
		logic [1:0] buzz_khz; // tone code, (code+1) kHz
		logic [15:0] buzz_ms; // longest buzz, in ms
		logic mutex_en; // mutually exclusive buttons
		logic timeout_en; // touch timeout
		logic [15:0] timeout_ms; // touch timeout, in ms
		logic selftest_en; // startup self-test
		logic [11:0] sense_en; // enabled sensing inputs
		logic [11:0] slider_mask; // inputs owned by the slider
	} tfa_cfg_t;

	// one event toward the host event buffer
	typedef struct packed {
		logic valid; // one-cycle pulse
		logic is_release; // 1: release, 0: touch
		logic [3:0] index; // sensing input number
	} tfa_evt_t;

	// touch delta of each sensing input
	typedef logic [11:0][15:0] tfa_delta_t;

	// startup sequence
	typedef enum logic [1:0] {
		TFA_WAIT = 2'b00,
		TFA_TEST = 2'b01,
		TFA_SIGNAL = 2'b10,
		TFA_RUN = 2'b11
	} tfa_state_t;

endpackage

/* File: src/tfa_tone.sv */
/*
 * square-wave tone generator for the buzzer.
 * assumes: run and khz come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tfa_defs.svh"

module tfa_tone import tfa_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [1:0] khz,
	output logic wave
);

	// ------------------------------------------------------------
	// half-period lookup
	// ------------------------------------------------------------
	// a table instead of a divider: only four tones exist
	function automatic logic [14:0] half_of(input logic [1:0] k);
		unique case (k)
			2'h0: half_of = 15'(`TFA_BUZZ_HALF(0));
			2'h1: half_of = 15'(`TFA_BUZZ_HALF(1));
			2'h2: half_of = 15'(`TFA_BUZZ_HALF(2));
			2'h3: half_of = 15'(`TFA_BUZZ_HALF(3));
		endcase
	endfunction

	logic [14:0] cnt; // cycles into the current half period
	logic [14:0] next_cnt;
	logic next_wave;

	// next values: wave and counter rest at zero while idle
	always_comb begin
		next_cnt = cnt + 15'h0001;
		next_wave = wave;
		if (!run) begin
			next_cnt = 15'h0000;
			next_wave = 1'b0;
		end else if (cnt >= half_of(khz) - 15'h0001) begin
			next_cnt = 15'h0000; // RULE4
			next_wave = ~wave;
		end
	end

	// registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 15'h0000;
			wave <= 1'b0;
		end else begin
			cnt <= next_cnt;
			wave <= next_wave;
		end
	end

endmodule
`default_nettype wire

/* File: verif/testbench.sv */
/*
 * self-checking bench for tfa_core with the host model.
 * assumes: short ms timebase, qualification driven directly.
 */
`timescale 1ns/1ps
`default_nettype none
// ----------------
// bench
// ----------------
module testbench;
	import tfa_pkg::*;
	localparam int MS = 4;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	tfa_cfg_t cfg;
	logic [11:0] qual_active, test_fault, scan_enable, timeout_release;
	tfa_delta_t touch_delta;
	logic test_done, pkt_pending, scan_start, test_req, event_irq_out, slave_ack_ok, buzz_pin_out, buzz_pin_oe_n;
	tfa_evt_t host_evt;
	tfa_evt_t exp_q[$]; // expected host events, oldest first
	int n_errors = 0;
	int n_compared = 0;
	int n_tmo = 0; // forced release pulses seen so far
	int k;
	logic [3:0] hi, lo;
	always #12.5 clk = ~clk;
	tfa_core #(.MS_CYCLES(MS)) i_dut (.clk(clk), .rstn(rstn), .cfg(cfg), .qual_active(qual_active),
		.touch_delta(touch_delta), .test_done(test_done), .test_fault(test_fault), .pkt_pending(pkt_pending),
		.scan_enable(scan_enable), .scan_start(scan_start), .test_req(test_req), .host_evt(host_evt),
		.timeout_release(timeout_release), .event_irq_out(event_irq_out), .slave_ack_ok(slave_ack_ok),
		.buzz_pin_out(buzz_pin_out), .buzz_pin_oe_n(buzz_pin_oe_n));
	tfa_host i_host (.clk(clk), .rstn(rstn), .host_evt(host_evt), .slave_ack_ok(slave_ack_ok),
		.pkt_pending(pkt_pending));
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (exp !== got) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	// note up to two events, apply the inputs, let them settle
	task automatic step(logic [11:0] v, int n, logic [4:0] e0, logic [4:0] e1);
		if (n > 0) exp_q.push_back({1'b1, e0});
		if (n > 1) exp_q.push_back({1'b1, e1});
		qual_active = v;
		tick(3);
	endtask
	task automatic buzz(logic od);
		int half;
		int t0;
		t0 = n_tmo;
		half = 40000000 / (2000 * (cfg.buzz_khz + 1));
		exp_q.push_back(6'h24);
		qual_active = 12'h010;
		k = 0;
		while (k < 25000 && (od ? buzz_pin_oe_n : buzz_pin_out) !== 1'b1) begin
			tick(1);
			k++;
		end
		check("tone delay", 1, k >= half && k <= half + 4);
		check("pin level", !od, buzz_pin_out);
		step(12'h000, 1, 5'h14, 5'h00);
		check("idle pin", 0, buzz_pin_out);
		check("idle oe", 0, buzz_pin_oe_n);
		check("timeout pulses", 16'(t0 + 1), 16'(n_tmo));
	endtask
	task automatic stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// oldest note against each event as it appears
	always @(negedge clk) begin
		if (rstn && timeout_release !== 12'h000) n_tmo += $countones(timeout_release);
		if (rstn && host_evt.valid === 1'b1) begin
			if (exp_q.size() == 0) check("extra event", 0, 1);
			else check("event", 16'(exp_q.pop_front()), 16'(host_evt));
		end
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		stop_test();
	end
	initial begin
		void'($urandom(87));
		cfg = '0;
		cfg.buzz_en = 1'b1;
		cfg.buzz_khz = 2'($urandom_range(3));
		cfg.buzz_ms = 16'hFFFF;
		cfg.mutex_en = 1'b1;
		cfg.timeout_en = 1'b1;
		cfg.timeout_ms = 16'h0010;
		cfg.selftest_en = 1'b1;
		cfg.sense_en = 12'hFFE;
		cfg.slider_mask = 12'h080;
		qual_active = 12'h000;
		touch_delta = '0;
		test_done = 1'b0;
		test_fault = 12'h000;
		tick(4);
		rstn = 1'b1;
		for (k = 0; k < 50 && test_req !== 1'b1; k++) tick(1);
		test_done = 1'b1;
		test_fault = 12'h005;
		tick(1);
		check("irq blink", 0, event_irq_out);
		test_done = 1'b0;
		test_fault = 12'($urandom);
		for (k = 0; k < 3000 * MS && scan_start !== 1'b1; k++) tick(1);
		check("signal span", 1, k >= 1999 * MS && k <= 2000 * MS + 2);
		check("scan mask", 12'h7FA, scan_enable);
		buzz(1'b0);
		touch_delta[3] = 16'($urandom);
		touch_delta[5] = touch_delta[3] ^ 16'($urandom_range(1, 65535));
		hi = (touch_delta[5] > touch_delta[3]) ? 4'h5 : 4'h3;
		lo = (hi == 4'h5) ? 4'h3 : 4'h5;
		step(12'h028, 1, {1'b0, hi}, 5'h00);
		step(12'h001 << lo, 2, {1'b1, hi}, {1'b0, lo});
		step(12'h000, 1, {1'b1, lo}, 5'h00);
		step(12'h100, 1, 5'h08, 5'h00);
		step(12'h780, 0, 5'h00, 5'h00);
		step(12'h680, 2, 5'h18, 5'h0A);
		step(12'h480, 0, 5'h00, 5'h00);
		step(12'h080, 1, 5'h1A, 5'h00);
		step(12'h000, 0, 5'h00, 5'h00);
		step(12'h100, 1, 5'h08, 5'h00);
		step(12'h700, 0, 5'h00, 5'h00);
		step(12'h300, 0, 5'h00, 5'h00);
		step(12'h200, 2, 5'h18, 5'h09);
		step(12'h000, 1, 5'h19, 5'h00);
		check("queue", 0, 16'(exp_q.size()));
		rstn = 1'b0;
		cfg.selftest_en = 1'b0;
		cfg.buzz_od = 1'b1;
		tick(4);
		check("reset irq", 1, event_irq_out);
		rstn = 1'b1;
		tick(2);
		check("scan start", 1, scan_start);
		check("scan mask", 12'h7FE, scan_enable);
		buzz(1'b1);
		tick(5);
		check("queue", 0, 16'(exp_q.size()));
		stop_test();
	end
endmodule
`default_nettype wire

/* File: verif/tfa_core_asserts.sv */
/*
 * port checker for tfa_core, bound to every instance.
 * assumes: one clock, rstn async active low, cfg static.
 */
`timescale 1ns/1ps
`default_nettype none
// ----------------
// checker
// ----------------
module tfa_core_chk import tfa_pkg::*; #(
	parameter int MS_CYCLES = 40000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire tfa_cfg_t cfg,
	input wire logic [11:0] qual_active,
	input wire logic pkt_pending,
	input wire logic [11:0] scan_enable,
	input wire logic scan_start,
	input wire logic test_req,
	input wire tfa_evt_t host_evt,
	input wire logic [11:0] timeout_release,
	input wire logic event_irq_out,
	input wire logic slave_ack_ok,
	input wire logic buzz_pin_out,
	input wire logic buzz_pin_oe_n
);
	localparam int PER = 250 * MS_CYCLES; // one blink level
	logic rep_busy; // a button is reported
	logic [3:0] rep_idx; // which one
	logic prev_irq;
	int tog_cnt; // cycles since the last irq change
	int n_tog;
	// follows the host-visible state; first blink gap skipped (short ms)
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rep_busy <= 1'b0;
			rep_idx <= 4'h0;
			prev_irq <= 1'b1;
			tog_cnt <= 0;
			n_tog <= 0;
		end else begin
			prev_irq <= event_irq_out;
			tog_cnt <= (event_irq_out != prev_irq) ? 0 : tog_cnt + 1;
			n_tog <= n_tog + int'(event_irq_out != prev_irq);
			if (host_evt.valid) begin
				rep_busy <= !host_evt.is_release;
				rep_idx <= host_evt.index;
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_ACK: assert property (slave_ack_ok == (scan_start && !event_irq_out))
		else $error("ack permission wrong");
	AST_IRQ_PKT: assert property (scan_start && $past(scan_start) |-> event_irq_out == !$past(pkt_pending))
		else $error("irq does not follow pending");
	AST_TOGGLE: assert property (event_irq_out != prev_irq && !scan_start && n_tog > 1 |-> tog_cnt == PER - 1)
		else $error("blink period wrong");
	AST_MUTEX: assert property (cfg.mutex_en && host_evt.valid && !host_evt.is_release |-> !rep_busy)
		else $error("second button reported");
	AST_MUTEX_REL: assert property (cfg.mutex_en && host_evt.valid && host_evt.is_release |-> rep_busy && host_evt.index == rep_idx)
		else $error("release of unreported button");
	AST_TIMEOUT: assert property (cfg.mutex_en && |(timeout_release & ~cfg.slider_mask) |-> (timeout_release & ~cfg.slider_mask) == (12'h001 << rep_idx))
		else $error("timeout on unreported button");
	AST_SLIDER: assert property (host_evt.valid |-> !cfg.slider_mask[host_evt.index])
		else $error("slider input reported");
	AST_TESTREQ: assert property (test_req |-> !scan_start && scan_enable == 12'h000)
		else $error("scan before self-test");
	AST_BUZZ_SENSE: assert property (cfg.buzz_en |-> !scan_enable[11])
		else $error("input eleven scanned");
	AST_PP: assert property (cfg.buzz_en && !cfg.buzz_od && scan_start |-> !buzz_pin_oe_n)
		else $error("push-pull not driving");
	AST_BUZZ_IDLE: assert property ((cfg.buzz_en && (qual_active & scan_enable) == 12'h000) [*4] |=> !buzz_pin_out)
		else $error("buzzer not idle low");
	COV_TOUCH: cover property (host_evt.valid && !host_evt.is_release);
	COV_BLINK: cover property (event_irq_out != prev_irq && !scan_start && n_tog > 1);
	COV_BUZZ: cover property ($rose(buzz_pin_out));
endmodule
bind tfa_core tfa_core_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk(clk), .rstn(rstn), .cfg(cfg),
	.qual_active(qual_active), .pkt_pending(pkt_pending), .scan_enable(scan_enable), .scan_start(scan_start),
	.test_req(test_req), .host_evt(host_evt), .timeout_release(timeout_release), .event_irq_out(event_irq_out),
	.slave_ack_ok(slave_ack_ok), .buzz_pin_out(buzz_pin_out), .buzz_pin_oe_n(buzz_pin_oe_n));
`default_nettype wire

/* File: verif/tfa_host.sv */
/*
 * host and event buffer model: counts packets, reads them slowly.
 * assumes: clk shared with tfa_core.
 */
`timescale 1ns/1ps
`default_nettype none
// ----------------
// host model
// ----------------
module tfa_host import tfa_pkg::*; #(
	parameter int DLY = 3
) (
	input wire logic clk,
	input wire logic rstn,
	input wire tfa_evt_t host_evt,
	input wire logic slave_ack_ok,
	output logic pkt_pending
);
	int n_pkt; // packets waiting
	int wait_cnt; // host latency per read
	logic rd;
	// reads only while the device grants the address
	assign rd = slave_ack_ok && wait_cnt == DLY;
	assign pkt_pending = n_pkt != 0;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			n_pkt <= 0;
			wait_cnt <= 0;
		end else begin
			n_pkt <= n_pkt + int'(host_evt.valid) - int'(rd);
			wait_cnt <= (slave_ack_ok && !rd) ? wait_cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire
